//--- rds_pkg.sv
package rds_pkg;

    // cyclic diagnostic module exchange
    typedef struct packed {
        logic       valid;
        logic [7:0] b3;
        logic [7:0] b2;
        logic [7:0] b1;
        logic [7:0] b0;
    } rds_query_s;

    typedef struct packed {
        logic [7:0] b3;
        logic [7:0] b2;
        logic [7:0] b1;
        logic [7:0] b0;
    } rds_reply_s;

    // preferred output state of the selected module/channel
    typedef struct packed {
        logic        keep;
        logic [15:0] value;
    } rds_fail_s;

    // instruction codes
    localparam logic [7:0] OP_NOP     = 8'h00;
    localparam logic [7:0] OP_VERSION = 8'h01;
    localparam logic [7:0] OP_STATUS  = 8'h02;
    localparam logic [7:0] OP_PREF    = 8'h03;
    localparam logic [7:0] OP_PREFRST = 8'h04;
    localparam logic [7:0] OP_STORE   = 8'h05;
    localparam logic [7:0] STORE_BUSY = 8'h85;
    localparam logic [7:0] PREF_OK    = 8'h00;
    localparam logic [7:0] PREF_REJ   = 8'hff;

    // extended diagnostic octets
    localparam logic [7:0] HDR_DEVICE = 8'h02;
    localparam logic [7:0] DEV_FAIL   = 8'hff;
    localparam logic [7:0] HDR_IDENT  = 8'h43;
    localparam int         EXT_FIRST  = 7;
    localparam logic [2:0] LEN_NONE   = 3'h0;
    localparam logic [2:0] LEN_DEV    = 3'h2;
    localparam logic [2:0] LEN_ID     = 3'h3;
    localparam logic [2:0] LEN_BOTH   = 3'h5;

    // status 0 bit positions
    localparam int ST_DIAG  = 7;
    localparam int ST_PWR   = 6;
    localparam int ST_EEP   = 5;
    localparam int ST_CLEAR = 4;
    localparam int ST_LOCK  = 3;

    // register map (byte addresses)
    localparam logic [7:0] ADDR_VERSION = 8'h00;
    localparam logic [7:0] ADDR_MODCNT  = 8'h04;
    localparam logic [7:0] ADDR_CONTROL = 8'h08;
    localparam logic [7:0] ADDR_STATUS  = 8'h0c;

    // reset values; version value is arbitrary
    localparam logic [23:0] RST_VERSION = 24'h010000;
    localparam logic [4:0]  RST_MODCNT  = 5'h10;
    localparam int          MOD_NUM     = 16;
    localparam int          CH_NUM      = 8;
    localparam int          PREF_NUM    = MOD_NUM * CH_NUM;
    localparam int          SYNC_W      = 22;

endpackage : rds_pkg

//--- rds_diag.sv
`timescale 1ns/100ps
module rds_diag (
    input  wire logic                hclk,
    input  wire logic                hresetn,
    input  wire logic                hsel,
    input  wire logic [7:0]          haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic      [31:0]         hrdata,
    output logic                     hreadyout,
    output logic                     hresp,
    input  wire rds_pkg::rds_query_s query,
    output rds_pkg::rds_reply_s      reply,
    output logic                     reply_valid,
    output logic                     busy,
    output logic                     store_req,
    input  wire logic                store_done,
    input  wire logic                ext_power_fail,
    input  wire logic                cable_fail,
    input  wire logic [15:0]         module_err,
    input  wire logic                bus_lost,
    input  wire logic                master_stop,
    input  wire logic                clear_seen,
    input  wire logic                lock_on,
    output logic [4:0][7:0]          ext_diag,
    output logic [2:0]               ext_len,
    output logic                     fail_active,
    input  wire logic [7:0]          fail_sel,
    output rds_pkg::rds_fail_s       fail_out
);
    import rds_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [6:0] pref_idx(input logic [7:0] pos);
        pref_idx = {pos[3:0], pos[6:4]};
    endfunction : pref_idx

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers, change taken when stages two and three agree

    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    logic [SYNC_W-1:0] sync3;
    logic [SYNC_W-1:0] pins;
    logic              pwr_s;
    logic              cable_s;
    logic              lost_s;
    logic              stop_s;
    logic              clear_s;
    logic              lock_s;
    logic [15:0]       moderr_s;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
            pins  <= '0;
        end
        else
        begin
            sync1 <= {ext_power_fail, cable_fail, bus_lost, master_stop,
                      clear_seen, lock_on, module_err};
            sync2 <= sync1;
            sync3 <= sync2;
            pins  <= (sync2 & sync3) | (pins & (sync2 | sync3));
        end
    end

    assign {pwr_s, cable_s, lost_s, stop_s, clear_s, lock_s, moderr_s} = pins;

    ////////////////////////////////////////////////////////////////////////
    // registers over AHB-Lite

    logic [23:0] version;
    logic [4:0]  mod_count;
    logic        eep_valid;
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic [7:0]  status0;
    logic        addr_ok;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign addr_ok   = hsel && htrans[1] && hready;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end
        else
        begin
            wr_pend <= addr_ok && hwrite;
            wr_addr <= haddr;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            version   <= RST_VERSION;
            mod_count <= RST_MODCNT;
        end
        else if (wr_pend)
        begin
            if (wr_addr == ADDR_VERSION)
                version <= hwdata[23:0];
            if (wr_addr == ADDR_MODCNT)
                mod_count <= hwdata[4:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h00000000;
        else if (addr_ok && !hwrite)
        begin
            case (haddr)
                ADDR_VERSION: hrdata <= {8'h00, version};
                ADDR_MODCNT:  hrdata <= {27'h0000000, mod_count};
                ADDR_CONTROL: hrdata <= {31'h00000000, eep_valid};
                ADDR_STATUS:  hrdata <= {20'h00000, ext_len, busy, status0};
                default:      hrdata <= 32'h00000000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // extended diagnostic octets 7..11

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ext_diag <= '0;
            ext_len  <= LEN_NONE;
        end
        else if ((pwr_s || cable_s) && (moderr_s != 16'h0000))
        begin
            ext_diag <= {moderr_s[15:8], moderr_s[7:0], HDR_IDENT,
                         DEV_FAIL, HDR_DEVICE};
            ext_len  <= LEN_BOTH;
        end
        else if (pwr_s || cable_s)
        begin
            ext_diag <= {8'h00, 8'h00, 8'h00, DEV_FAIL, HDR_DEVICE};
            ext_len  <= LEN_DEV;
        end
        else if (moderr_s != 16'h0000)
        begin
            ext_diag <= {8'h00, 8'h00, moderr_s[15:8], moderr_s[7:0],
                         HDR_IDENT};
            ext_len  <= LEN_ID;
        end
        else
        begin
            ext_diag <= '0;
            ext_len  <= LEN_NONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status byte 0

    assign status0 = {ext_len != LEN_NONE, pwr_s, eep_valid, clear_s,
                      lock_s, 3'h0};

    ////////////////////////////////////////////////////////////////////////
    // instruction interpreter

    logic [15:0]         pref_value [0:PREF_NUM-1];
    logic [PREF_NUM-1:0] pref_set;
    logic [PREF_NUM-1:0] pref_keep;
    logic                take;
    logic                pref_ok;
    logic [6:0]          q_idx;
    assign take    = query.valid && !busy;
    assign q_idx   = pref_idx(query.b2);
    assign pref_ok = {1'b0, query.b2[3:0]} < mod_count;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            reply       <= '0;
            reply_valid <= 1'b0;
            store_req   <= 1'b0;
            busy        <= 1'b0;
        end
        else
        begin
            reply_valid <= take || (busy && store_done);
            store_req   <= 1'b0;
            if (busy && store_done)
            begin
                busy     <= 1'b0;
                reply.b3 <= OP_STORE;
            end
            else if (take)
            begin
                reply.b3 <= query.b3;
                case (query.b3)
                    OP_NOP:
                        {reply.b2, reply.b1, reply.b0}
                            <= {query.b2, query.b1, query.b0};
                    OP_VERSION:
                        {reply.b0, reply.b1, reply.b2} <= version;
                    OP_STATUS:
                        {reply.b2, reply.b1, reply.b0}
                            <= {8'h00, 8'h00, status0};
                    OP_PREF:
                        {reply.b2, reply.b1, reply.b0}
                            <= {query.b2, 8'h00, pref_ok ? PREF_OK : PREF_REJ};
                    OP_STORE:
                    begin
                        reply.b3  <= STORE_BUSY;
                        busy      <= 1'b1;
                        store_req <= 1'b1;
                    end
                    default:
                        {reply.b2, reply.b1, reply.b0} <= 24'h000000;
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            eep_valid <= 1'b0;
        else if (busy && store_done)
            eep_valid <= 1'b1;
        else if (wr_pend && wr_addr == ADDR_CONTROL && hwdata[0])
            eep_valid <= 1'b0;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pref_set  <= '0;
            pref_keep <= '0;
        end
        else if (take && query.b3 == OP_PREFRST)
        begin
            pref_set  <= '0;
            pref_keep <= '0;
        end
        else if (take && query.b3 == OP_PREF && pref_ok)
        begin
            pref_set[q_idx]  <= 1'b1;
            pref_keep[q_idx] <= query.b2[7];
        end
    end

    always_ff @(posedge hclk)
    begin
        if (take && query.b3 == OP_PREF && pref_ok && !query.b2[7])
            pref_value[q_idx] <= {query.b0, query.b1};
    end

    ////////////////////////////////////////////////////////////////////////
    // failure output states

    logic [6:0] f_idx;
    assign f_idx = pref_idx(fail_sel);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            fail_active <= 1'b0;
            fail_out    <= '0;
        end
        else
        begin
            fail_active <= lost_s || stop_s;
            if (!pref_set[f_idx])
                fail_out <= '0;
            else if (pref_keep[f_idx])
                fail_out <= {1'b1, 16'h0000};
            else
                fail_out <= {1'b0, pref_value[f_idx]};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    sequence s_take(logic [7:0] code);
        query.valid && !busy && query.b3 == code;
    endsequence

    a_nop_echo: assert property (@(posedge hclk) disable iff (!hresetn)
        s_take(OP_NOP) |=> reply == {8'h00, $past(query.b2), $past(query.b1),
                                     $past(query.b0)})
        else $error("nop reply not echoed");
    a_version_reply: assert property (@(posedge hclk) disable iff (!hresetn)
        s_take(OP_VERSION) |=> reply.b3 == OP_VERSION
                               && {reply.b0, reply.b1, reply.b2} == $past(version))
        else $error("version reply wrong");
    a_status_reply: assert property (@(posedge hclk) disable iff (!hresetn)
        s_take(OP_STATUS) |=> reply.b0 == $past(status0) && reply.b2 == 8'h00
                              && reply.b1 == 8'h00)
        else $error("status reply wrong");
    a_busy_refuse: assert property (@(posedge hclk) disable iff (!hresetn)
        busy && !store_done |=> reply == $past(reply) && !store_req)
        else $error("instruction taken while busy");
    a_store_flow: assert property (@(posedge hclk) disable iff (!hresetn)
        s_take(OP_STORE) |=> store_req && busy && reply.b3 == STORE_BUSY
                             ##1 !store_req)
        else $error("store start wrong");
    a_store_end: assert property (@(posedge hclk) disable iff (!hresetn)
        busy && store_done |=> !busy && reply.b3 == OP_STORE && eep_valid)
        else $error("store end wrong");
    a_pref_answer: assert property (@(posedge hclk) disable iff (!hresetn)
        s_take(OP_PREF) |=> reply.b0 == ($past(pref_ok) ? PREF_OK : PREF_REJ)
                            && reply.b2 == $past(query.b2))
        else $error("preferred state answer wrong");
    a_dev_diag: assert property (@(posedge hclk) disable iff (!hresetn)
        ext_len == LEN_DEV |-> ext_diag[0] == HDR_DEVICE && ext_diag[1] == DEV_FAIL)
        else $error("device diagnostic wrong");
    a_pack_both: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(ext_len == LEN_BOTH) |-> ext_diag[2] == HDR_IDENT
            && {ext_diag[4], ext_diag[3]} == $past(moderr_s))
        else $error("packed diagnostic wrong");
    a_fail_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        !pref_set[f_idx] |=> fail_out == '0)
        else $error("default failure state not zero");
    a_fail_follow: assert property (@(posedge hclk) disable iff (!hresetn)
        lost_s ##1 lost_s |-> fail_active [*2])
        else $error("failure mode not entered");

endmodule : rds_diag

//--- rds_master_model.sv
`timescale 1ns/100ps
// polling master of the diagnostic module exchange
module rds_master_model
(
    input  wire logic                hclk,
    output rds_pkg::rds_query_s      query,
    input  wire rds_pkg::rds_reply_s reply,
    input  wire logic                reply_valid
);
    import rds_pkg::*;

    initial query = '0;

    ////////////////////////////////////////////////////////////////////////
    // diagnostic module sits after the last i/o slot of this master
    task xfer(input logic [7:0] code, input logic [23:0] d,
              output rds_reply_s r, output logic got, output logic ok);
        int i;
        got = 1'b0;
        i = 0;
        // one clock keeps the last release apart from this request
        @(posedge hclk);
        #1;
        query <= {1'b1, code, d};
        @(posedge hclk);
        #1;
        // released bytes must not look like the last request
        query <= {1'b0, ~code, ~d};
        while (i < 4 && got !== 1'b1)
        begin
            if (reply_valid === 1'b1)
                got = 1'b1;
            else
            begin
                @(posedge hclk);
                #1;
            end
            i++;
        end
        r = reply;
        ok = got && (reply.b3 === code);
    endtask : xfer

endmodule : rds_master_model

//--- rds_diag_tb_top.sv
`timescale 1ns/100ps
`define CHK(nm, e, a) \
    begin \
        n_checks++; \
        if ((a) !== (e)) \
        begin \
            n_fail++; \
            $display("mismatch %s exp %h got %h", nm, e, a); \
        end \
    end
module rds_diag_tb_top;
    import rds_pkg::*;

    logic                hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [7:0]          haddr, fail_sel;
    logic [1:0]          htrans;
    logic [2:0]          hsize, ext_len;
    logic [31:0]         hwdata, hrdata, rd;
    rds_query_s          query;
    rds_reply_s          reply, r;
    logic                reply_valid, busy, store_req, store_done, got, ok;
    logic                ext_power_fail, cable_fail, bus_lost, master_stop;
    logic                clear_seen, lock_on, fail_active;
    logic [15:0]         module_err;
    logic [4:0][7:0]     ext_diag;
    rds_fail_s           fail_out;
    int                  n_fail, n_checks;

    assign hready = hreadyout;

    rds_diag uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .query(query), .reply(reply), .reply_valid(reply_valid), .busy(busy),
        .store_req(store_req), .store_done(store_done),
        .ext_power_fail(ext_power_fail), .cable_fail(cable_fail),
        .module_err(module_err), .bus_lost(bus_lost), .master_stop(master_stop),
        .clear_seen(clear_seen), .lock_on(lock_on), .ext_diag(ext_diag),
        .ext_len(ext_len), .fail_active(fail_active), .fail_sel(fail_sel),
        .fail_out(fail_out));

    rds_master_model master (.hclk(hclk), .query(query), .reply(reply),
        .reply_valid(reply_valid));

    initial
    begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end

    ////////////////////////////////////////////////////////////////////////
    task tick(input int n);
        repeat (n)
        begin
            @(posedge hclk);
            #1;
        end
    endtask : tick

    task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        do tick(1); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do tick(1); while (hready !== 1'b1);
        rd = hrdata;
    endtask : ahb

    task test_done;
        if (n_fail == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : test_done

    ////////////////////////////////////////////////////////////////////////
    task t_regs;
        ahb(0, ADDR_VERSION, 0);
        `CHK("version", {8'h00, RST_VERSION}, rd);
        ahb(0, ADDR_MODCNT, 0);
        `CHK("modcnt", {27'h0, RST_MODCNT}, rd);
        ahb(1, 8'h40, 32'hffffffff);
        ahb(0, 8'h40, 0);
        `CHK("unmapped", 32'h0, rd);
        `CHK("hresp", 1'b0, hresp);
        ahb(1, ADDR_VERSION, 32'h00123456);
        master.xfer(OP_VERSION, 24'h0, r, got, ok);
        `CHK("ver_reply", {OP_VERSION, 24'h563412}, r);
        `CHK("ver_ok", 1'b1, ok);
        ahb(1, ADDR_VERSION, {8'h00, RST_VERSION});
        master.xfer(OP_NOP, 24'hc3a55a, r, got, ok);
        `CHK("nop", {OP_NOP, 24'hc3a55a}, r);
        master.xfer(8'h07, 24'hffffff, r, got, ok);
        `CHK("undef", 32'h07000000, r);
    endtask : t_regs

    task t_diag;
        ext_power_fail <= 1'b1;
        module_err <= 16'h8001;
        clear_seen <= 1'b1;
        lock_on <= 1'b1;
        tick(8);
        `CHK("len_both", LEN_BOTH, ext_len);
        `CHK("both", {16'h8001, HDR_IDENT, DEV_FAIL, HDR_DEVICE}, ext_diag);
        master.xfer(OP_STATUS, 24'h0, r, got, ok);
        `CHK("status", {OP_STATUS, 16'h0, 8'hd8}, r);
        ext_power_fail <= 1'b0;
        cable_fail <= 1'b1;
        module_err <= 16'h0;
        tick(8);
        `CHK("len_dev", LEN_DEV, ext_len);
        `CHK("dev", {DEV_FAIL, HDR_DEVICE}, ext_diag[1:0]);
        cable_fail <= 1'b0;
        module_err <= 16'h0100;
        tick(8);
        `CHK("len_id", LEN_ID, ext_len);
        `CHK("ident", {16'h0100, HDR_IDENT}, ext_diag[2:0]);
        module_err <= 16'h0;
        clear_seen <= 1'b0;
        lock_on <= 1'b0;
        tick(8);
        `CHK("len_none", LEN_NONE, ext_len);
    endtask : t_diag

    task t_pref;
        master.xfer(OP_PREF, 24'h25cdab, r, got, ok);
        `CHK("pref", {OP_PREF, 8'h25, 8'h00, PREF_OK}, r);
        fail_sel <= 8'h25;
        tick(1);
        `CHK("pref_val", {1'b0, 16'habcd}, fail_out);
        fail_sel <= 8'h35;
        tick(1);
        `CHK("unset", 17'h0, fail_out);
        master.xfer(OP_PREF, 24'h821122, r, got, ok);
        `CHK("keep_rep", {OP_PREF, 8'h82, 16'h0}, r);
        fail_sel <= 8'h02;
        tick(1);
        `CHK("keep", {1'b1, 16'h0}, fail_out);
        ahb(1, ADDR_MODCNT, 32'h4);
        master.xfer(OP_PREF, 24'h071234, r, got, ok);
        `CHK("reject", {OP_PREF, 8'h07, 8'h00, PREF_REJ}, r);
        ahb(1, ADDR_MODCNT, {27'h0, RST_MODCNT});
        bus_lost <= 1'b1;
        tick(6);
        `CHK("lost", 1'b1, fail_active);
        bus_lost <= 1'b0;
        master_stop <= 1'b1;
        tick(6);
        `CHK("stop", 1'b1, fail_active);
        master_stop <= 1'b0;
        tick(6);
        `CHK("run", 1'b0, fail_active);
        master.xfer(OP_PREFRST, 24'h0, r, got, ok);
        `CHK("rst_echo", OP_PREFRST, r.b3);
        fail_sel <= 8'h25;
        tick(1);
        `CHK("rst_val", 17'h0, fail_out);
    endtask : t_pref

    task t_store;
        master.xfer(OP_STORE, 24'h0, r, got, ok);
        `CHK("st_busy", STORE_BUSY, r.b3);
        `CHK("st_req", 1'b1, store_req);
        master.xfer(OP_NOP, 24'h111111, r, got, ok);
        `CHK("refused", 1'b0, got);
        ahb(0, ADDR_STATUS, 0);
        `CHK("busy", 1'b1, rd[8]);
        store_done <= 1'b1;
        tick(1);
        store_done <= 1'b0;
        `CHK("idle", 1'b0, busy);
        `CHK("st_end", OP_STORE, reply.b3);
        master.xfer(OP_STATUS, 24'h0, r, got, ok);
        `CHK("eep", {OP_STATUS, 24'h000020}, r);
        ahb(1, ADDR_CONTROL, 32'h1);
        store_done <= 1'b1;
        tick(1);
        store_done <= 1'b0;
        tick(1);
        ahb(0, ADDR_CONTROL, 0);
        `CHK("stray_done", 1'b0, rd[0]);
    endtask : t_store

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        n_fail = 0;
        n_checks = 0;
        hresetn = 1'b0;
        {hsel, hwrite, store_done, ext_power_fail, cable_fail} = '0;
        {bus_lost, master_stop, clear_seen, lock_on} = '0;
        haddr = '0;
        htrans = '0;
        hsize = 3'h2;
        hwdata = '0;
        module_err = '0;
        fail_sel = '0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        tick(1);
        t_regs();
        t_diag();
        t_pref();
        t_store();
        test_done();
    end

    initial
    begin
        repeat (4000) @(posedge hclk);
        n_fail++;
        test_done();
    end

endmodule : rds_diag_tb_top
